// ### bench/prq_mem_model.sv
// memory model that completes descriptor writes after a set latency
`timescale 1ns/10ps
`default_nettype none
module prq_mem_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_srst,
   input  wire logic       i_wr_valid,
   input  wire logic [3:0] i_lat,
   output logic            o_wr_done
);
   logic [3:0] cnt_r;
   // ====
   // count the latency, then pulse completion once per write
   always_ff @(posedge i_clk_sys) begin
      if (i_srst || !i_wr_valid || o_wr_done) begin
         cnt_r     <= 4'h0;
         o_wr_done <= 1'h0;
      end else if (cnt_r == i_lat) begin
         o_wr_done <= 1'h1;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule // prq_mem_model
`default_nettype wire

// ### bench/prq_regs_chk.sv
// assertion checker bound to the page request queue register block
`timescale 1ns/10ps
`default_nettype none
module prq_regs_chk (
   input wire logic        i_clk_sys,
   input wire logic        i_srst,
   input wire logic        i_page_request_supported,
   input wire logic [7:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic        i_entry_valid,
   input wire logic        o_mem_wr_valid,
   input wire logic [63:0] o_mem_wr_addr,
   input wire logic        i_mem_wr_done,
   input wire logic        o_pend_event
);
   // ====
   // bus answer timing and queue write ordering
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus answer late");
   answer_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("answer too long");
   off_read_a: assert property (!i_page_request_supported && i_avs_read && o_avs_waitrequest &&
      i_avs_address[7:5] == 3'h6 |=> o_avs_readdata == 32'h0) else $error("read while off");
   off_take_a: assert property ($rose(o_mem_wr_valid) |->
      $past(i_entry_valid) && $past(i_page_request_supported)) else $error("entry taken while off");
   wr_hold_a: assert property (o_mem_wr_valid && !i_mem_wr_done |=>
      o_mem_wr_valid && $stable(o_mem_wr_addr)) else $error("write dropped early");
   wr_align_a: assert property (o_mem_wr_valid |-> o_mem_wr_addr[3:0] == 4'h0)
      else $error("write not aligned");
   pend_after_a: assert property (o_pend_event |-> $past(i_mem_wr_done)) else $error("pending before write");
   pend_once_a: assert property (o_pend_event |=> !o_pend_event) else $error("pending event twice");
   status_rsvd_a: assert property (i_avs_read && o_avs_waitrequest && i_avs_address == 8'hDC |=>
      o_avs_readdata[31:1] == 31'h0) else $error("status reserved bits set");
endmodule // prq_regs_chk
bind prq_regs prq_regs_chk u_chk (.i_clk_sys, .i_srst, .i_page_request_supported, .i_avs_address, .i_avs_read,
   .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_entry_valid, .o_mem_wr_valid, .o_mem_wr_addr,
   .i_mem_wr_done, .o_pend_event);
`default_nettype wire

// ### bench/prq_regs_tb_top.sv
// self-checking testbench for the page request queue register block
`timescale 1ns/10ps
`default_nettype none
module prq_regs_tb_top;
   localparam int HOST_W = 40;
   logic                clk = 1'h0;
   logic                srst = 1'h1;
   logic                sup = 1'h1;
   logic                rd = 1'h0;
   logic                wr = 1'h0;
   logic                ev = 1'h0;
   logic [7:0]          adr = 8'h00;
   logic [31:0]         wd = 32'h0;
   logic [3:0]          lat = 4'h0;
   prq_pkg::prq_entry_s ent = '0;
   logic                rdy, mv, done, pe, irq, wreq;
   logic [31:0]         rdata, q;
   logic [63:0]         ma;
   int                  bad_count, tests_run, pe_cnt;
   logic [7:0]          offs [7] = '{8'hC0, 8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'hDC, 8'h40};
   // ====
   // design, memory partner, clock and pending event counter
   prq_regs #(.HOST_ADDR_W(HOST_W)) dut (.i_clk_sys(clk), .i_srst(srst), .i_page_request_supported(sup),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_entry_valid(ev), .i_entry(ent), .o_entry_ready(rdy),
      .o_mem_wr_valid(mv), .o_mem_wr_addr(ma), .i_mem_wr_done(done), .o_pend_event(pe), .o_irq(irq));
   prq_mem_model mem (.i_clk_sys(clk), .i_srst(srst), .i_wr_valid(mv), .i_lat(lat), .o_wr_done(done));
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (pe === 1'h1) pe_cnt++;
   // closing report
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // compare, and give up when a wait ran out
   task automatic ck(input string nm, input logic [63:0] e, input logic [63:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 60) begin
         bad_count++;
         end_sim();
      end
   endtask
   // one avalon-mm transfer, held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      rd  <= ~w;
      wr  <= w;
      adr <= a;
      wd  <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'h0 && n < 60);
      q = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
      @(posedge clk);
      tmo(n);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      acc(1'h0, a, 32'h0);
      ck(nm, 64'(e), 64'(q));
   endtask
   // offer one entry; when a write is due, check its address and let it finish
   task automatic push(input logic [1:0] f, input logic [63:0] ea, input logic x);
      int n;
      ent <= prq_pkg::prq_entry_s'(f);
      ev  <= 1'h1;
      @(posedge clk);
      ev <= 1'h0;
      n = 0;
      do @(posedge clk); while (mv !== x && ++n < 60);
      if (x) ck("write address", ea, ma);
      do @(posedge clk); while ((mv !== 1'h0 || rdy !== 1'h1) && ++n < 60);
      tmo(n);
   endtask
   // ====
   // test sequence
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'h0;
      foreach (offs[i]) rc(offs[i], 32'h0, "reset value");
      acc(1'h1, 8'hD0, 32'hFFFFFFFF);
      rc(8'hD0, 32'hFFFFF007, "base low");
      acc(1'h1, 8'hD4, 32'hFFFFFFFF);
      rc(8'hD4, (32'h1 << (HOST_W - 32)) - 32'h1, "base high");
      $display("test base done");
      acc(1'h1, 8'hD4, 32'h0);
      acc(1'h1, 8'hD0, 32'h00010000);
      push(2'h0, 64'h10000, 1'h1);
      rc(8'hDC, 32'h0, "pending plain");
      push(2'h2, 64'h10010, 1'h1);
      push(2'h1, 64'h10020, 1'h1);
      ck("pend events", 64'h1, 64'(pe_cnt));
      rc(8'hF0, 32'h3, "irq status");
      ck("irq masked", 64'h0, 64'(irq));
      acc(1'h1, 8'hF4, 32'h7);
      rc(8'hC8, 32'h30, "tail step");
      ck("irq raised", 64'h1, 64'(irq));
      acc(1'h1, 8'hDC, 32'h0);
      rc(8'hDC, 32'h1, "pending kept");
      acc(1'h1, 8'hDC, 32'h1);
      rc(8'hDC, 32'h0, "pending cleared");
      acc(1'h1, 8'hF8, 32'h7);
      rc(8'hF0, 32'h0, "irq cleared");
      ck("irq low", 64'h0, 64'(irq));
      $display("test append done");
      for (int i = 3; i < 255; i++) begin
         lat <= 4'(i % 5);
         push(2'h0, 64'h10000 + 64'(i) * 64'h10, 1'h1);
      end
      push(2'h0, 64'h0, 1'h0);
      rc(8'hC8, 32'hFF0, "tail at full");
      rc(8'hF0, 32'h6, "drop event");
      acc(1'h1, 8'hC0, 32'h100);
      push(2'h0, 64'h10FF0, 1'h1);
      rc(8'hC8, 32'h0, "tail wrap");
      $display("test wrap done");
      sup <= 1'h0;
      acc(1'h1, 8'hD0, 32'hFFFFFFFF);
      rc(8'hD0, 32'h0, "read while off");
      push(2'h2, 64'h0, 1'h0);
      sup <= 1'h1;
      rc(8'hD0, 32'h00010000, "write while off");
      rc(8'hDC, 32'h0, "entry while off");
      $display("test support done");
      end_sim();
   end
endmodule // prq_regs_tb_top
`default_nettype wire

// ### logic/prq_defines.svh
// register offsets, field positions, reset values and sizes for the page request queue registers
`ifndef PRQ_DEFINES_SVH
`define PRQ_DEFINES_SVH
`define PRQ_OFF_TAIL_LO    8'hC8
`define PRQ_OFF_TAIL_HI    8'hCC
`define PRQ_OFF_BASE_LO    8'hD0
`define PRQ_OFF_BASE_HI    8'hD4
`define PRQ_OFF_STATUS     8'hDC
`define PRQ_OFF_HEAD_LO    8'hC0
`define PRQ_OFF_HEAD_HI    8'hC4
`define PRQ_OFF_IRQ_STAT   8'hF0
`define PRQ_OFF_IRQ_EN     8'hF4
`define PRQ_OFF_IRQ_CLR    8'hF8
`define PRQ_TAIL_LSB       4
`define PRQ_TAIL_MSB       18
`define PRQ_BASE_LSB       12
`define PRQ_SIZE_MSB       2
`define PRQ_PEND_BIT       0
`define PRQ_ENTRY_SHIFT    8
`define PRQ_RESET_VAL      32'h00000000
`define PRQ_EVT_W          3
`endif

// ### logic/prq_pkg.sv
// types shared by the page request queue register block
`default_nettype none
package prq_pkg;
   // one entry presented for appending to the queue
   typedef struct packed {
      logic streaming_response_requested;
      logic last_page_in_group;
   } prq_entry_s;
   // interrupt event bits: pending set, entry written, entry dropped on full
   typedef enum logic [1:0] {
      PRQ_EVT_PEND = 2'h0,
      PRQ_EVT_WR   = 2'h1,
      PRQ_EVT_DROP = 2'h2
   } prq_evt_e;
   // append handshake state
   typedef enum logic [1:0] {
      PRQ_IDLE  = 2'h0,
      PRQ_WRITE = 2'h1,
      PRQ_ACK   = 2'h3
   } prq_state_e;
endpackage
`default_nettype wire

// ### logic/prq_regs.sv
// page request queue tail, base/size and pending status registers with avalon-mm slave
`timescale 1ns/10ps
`default_nettype none
`include "prq_defines.svh"
module prq_regs #(
   parameter int HOST_ADDR_W = 48
) (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_srst,
   input  wire logic                  i_page_request_supported,
   input  wire logic [7:0]            i_avs_address,
   input  wire logic                  i_avs_read,
   input  wire logic                  i_avs_write,
   input  wire logic [31:0]           i_avs_writedata,
   input  wire logic [3:0]            i_avs_byteenable,
   output logic [31:0]                o_avs_readdata,
   output logic                       o_avs_waitrequest,
   input  wire logic                  i_entry_valid,
   input  wire prq_pkg::prq_entry_s   i_entry,
   output logic                       o_entry_ready,
   output logic                       o_mem_wr_valid,
   output logic [63:0]                o_mem_wr_addr,
   input  wire logic                  i_mem_wr_done,
   output logic                       o_pend_event,
   output logic                       o_irq
);
   // refuse host address widths that the base register cannot hold
   if (HOST_ADDR_W < 13 || HOST_ADDR_W > 64) begin : g_bad_width
      $error("host address width out of range");
   end

   // ==========================================================
   // state
   logic [14:0]              tail_r;
   logic [14:0]              head_r;
   logic [51:0]              base_r;
   logic [2:0]               size_r;
   logic                     pend_r;
   logic [`PRQ_EVT_W-1:0]    irq_stat_r;
   logic [`PRQ_EVT_W-1:0]    irq_en_r;
   prq_pkg::prq_state_e      state_r;
   prq_pkg::prq_entry_s      entry_r;
   logic                     ack_r;

   // ==========================================================
   // bus decode
   wire logic        wr_acc   = i_avs_write & o_avs_waitrequest & ~ack_r;
   wire logic        rd_acc   = i_avs_read  & o_avs_waitrequest & ~ack_r;
   wire logic        sup      = i_page_request_supported;
   wire logic [31:0] be_mask  = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                                 {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   wire logic [31:0] wdat     = i_avs_writedata & be_mask;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // base bits at and above the host address width are ignored
   wire logic [51:0] haw_mask = 52'((64'h1 << HOST_ADDR_W) - 64'h1 >> `PRQ_BASE_LSB);

   // entry count mask: 2^(X+8) entries, tail index wraps there
   wire logic [14:0] wrap_mask = 15'((32'h1 << (32'(size_r) + `PRQ_ENTRY_SHIFT)) - 32'h1);
   wire logic [14:0] tail_inc  = (tail_r + 15'h1) & wrap_mask;
   wire logic        q_full    = (tail_inc == (head_r & wrap_mask));

   // read mux; reserved bits and unsupported registers read zero
   wire logic [31:0] rd_mux =
      !sup                                  ? 32'h0 :
      hit(i_avs_address, `PRQ_OFF_TAIL_LO)  ? {13'h0, tail_r, 4'h0} :
      hit(i_avs_address, `PRQ_OFF_HEAD_LO)  ? {13'h0, head_r, 4'h0} :
      hit(i_avs_address, `PRQ_OFF_BASE_LO)  ? {base_r[19:0], 9'h0, size_r} :
      hit(i_avs_address, `PRQ_OFF_BASE_HI)  ? base_r[51:20] :
      hit(i_avs_address, `PRQ_OFF_STATUS)   ? {31'h0, pend_r} :
      hit(i_avs_address, `PRQ_OFF_IRQ_STAT) ? {29'h0, irq_stat_r} :
      hit(i_avs_address, `PRQ_OFF_IRQ_EN)   ? {29'h0, irq_en_r} : 32'h0;

   wire logic wr_tail = wr_acc & sup & hit(i_avs_address, `PRQ_OFF_TAIL_LO);
   wire logic wr_head = wr_acc & sup & hit(i_avs_address, `PRQ_OFF_HEAD_LO);
   wire logic wr_blo  = wr_acc & sup & hit(i_avs_address, `PRQ_OFF_BASE_LO);
   wire logic wr_bhi  = wr_acc & sup & hit(i_avs_address, `PRQ_OFF_BASE_HI);
   wire logic wr_stat = wr_acc & sup & hit(i_avs_address, `PRQ_OFF_STATUS);
   wire logic wr_ien  = wr_acc & hit(i_avs_address, `PRQ_OFF_IRQ_EN);
   wire logic wr_iclr = wr_acc & hit(i_avs_address, `PRQ_OFF_IRQ_CLR);

   // ==========================================================
   // append engine: take entry, write memory, then update tail and flag
   wire logic take     = (state_r == prq_pkg::PRQ_IDLE) & i_entry_valid & sup;
   wire logic drop     = take & q_full;
   wire logic done     = (state_r == prq_pkg::PRQ_WRITE) & i_mem_wr_done;
   wire logic ppr_set  = done & (entry_r.streaming_response_requested | entry_r.last_page_in_group);
   wire logic new_cond = ppr_set & ~pend_r;
   wire logic [`PRQ_EVT_W-1:0] evt = {drop, done, new_cond};

   prq_pkg::prq_state_e state_nxt;
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         prq_pkg::PRQ_IDLE:  if (take && !q_full) state_nxt = prq_pkg::PRQ_WRITE;
         prq_pkg::PRQ_WRITE: if (i_mem_wr_done) state_nxt = prq_pkg::PRQ_ACK;
         prq_pkg::PRQ_ACK:   state_nxt = prq_pkg::PRQ_IDLE;
         default:            state_nxt = prq_pkg::PRQ_IDLE;
      endcase
   end

   // queue state registers
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         state_r <= prq_pkg::PRQ_IDLE;
         entry_r <= '0;
         tail_r  <= 15'h0;
         head_r  <= 15'h0;
         base_r  <= 52'h0;
         size_r  <= 3'h0;
      end else begin
         state_r <= state_nxt;
         if (take) entry_r <= i_entry;
         if (done) tail_r <= tail_inc;
         else if (wr_tail && i_avs_byteenable[0] && i_avs_byteenable[2])
            tail_r <= wdat[`PRQ_TAIL_MSB:`PRQ_TAIL_LSB];
         if (wr_head) head_r <= wdat[`PRQ_TAIL_MSB:`PRQ_TAIL_LSB];
         if (wr_blo) begin
            base_r[19:0] <= wdat[31:12] & haw_mask[19:0];
            size_r       <= wdat[`PRQ_SIZE_MSB:0];
         end
         if (wr_bhi) base_r[51:20] <= wdat & haw_mask[51:20];
      end
   end

   // pending flag: set beats a same-cycle clear
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         pend_r <= 1'b0;
      end else begin
         pend_r <= ppr_set | (pend_r & ~(wr_stat & wdat[`PRQ_PEND_BIT]));
      end
   end

   // interrupt status, enable and level output
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         irq_stat_r <= '0;
         irq_en_r   <= '0;
         o_irq      <= 1'b0;
      end else begin
         irq_stat_r <= evt | (irq_stat_r & ~(wr_iclr ? wdat[`PRQ_EVT_W-1:0] : '0));
         if (wr_ien) irq_en_r <= wdat[`PRQ_EVT_W-1:0];
         o_irq      <= |(irq_stat_r & irq_en_r);
      end
   end

   // bus answer: one wait cycle, then data and waitrequest low
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ack_r             <= 1'b0;
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= `PRQ_RESET_VAL;
      end else begin
         ack_r             <= wr_acc | rd_acc;
         o_avs_waitrequest <= ~(wr_acc | rd_acc);
         if (rd_acc) o_avs_readdata <= rd_mux;
      end
   end

   // memory side outputs
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_mem_wr_valid <= 1'b0;
         o_mem_wr_addr  <= 64'h0;
         o_entry_ready  <= 1'b0;
         o_pend_event   <= 1'b0;
      end else begin
         o_mem_wr_valid <= (state_nxt == prq_pkg::PRQ_WRITE) & ~i_mem_wr_done;
         if (take) o_mem_wr_addr <= {base_r, 12'h0} + {45'h0, tail_r, 4'h0};
         o_entry_ready  <= (state_nxt == prq_pkg::PRQ_IDLE);
         o_pend_event   <= new_cond;
      end
   end
endmodule // prq_regs
`default_nettype wire
